// ### drlr_host_model.sv
/*
  Remote host model: sends read commands, collects reply bytes.
  Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module drlr_host_model
  import drlr_pkg::*;
(
  input wire logic clk,         // Clock
  output logic rx_valid,        // Command valid
  output logic [7:0] rx_data,   // Command byte
  output logic rx_last,         // Command last
  input wire logic rx_ready,    // Command ready
  input wire logic tx_valid,    // Reply valid
  input wire logic [7:0] tx_data, // Reply byte
  input wire logic tx_last,     // Reply last
  output logic tx_ready,        // Reply ready
  input wire logic slow         // Stall replies
);
  logic [7:0] rep[$];
  int n_last = 0;
  logic [1:0] cyc = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Collect replies; when slow, refuse one cycle in four
  always @(posedge clk) begin
    if (tx_valid && tx_ready) rep.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last) n_last++;
    cyc <= cyc + 2'h1;
    #1 tx_ready = !slow || (cyc != 2'h0);
  end
  // One read packet; bad_ix flips one byte to provoke a refusal
  task automatic send_read(input logic [15:0] transaction_number, input logic [7:0] elem,
      input logic [3:0] bad_ix);
    logic [7:0] p[12];
    p = '{8'h01, 8'h02, CMD_READ, 8'h00, transaction_number[7:0], transaction_number[15:8], FNC_READ,
      SIZE_MAX, 8'h00, FTYPE_LOG, elem, 8'h00};
    if (bad_ix != RX_MAX_IX) p[bad_ix] = p[bad_ix] ^ 8'h01;
    for (int i = 0; i < 12; i++) begin
      rx_valid = 1'b1;
      rx_data = p[i];
      rx_last = (i == 11);
      while (!rx_ready) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data; // Released line must not keep its last value
  endtask
endmodule // drlr_host_model
`default_nettype wire

// ### drlr_pkg.sv
/*
  Shared constants for the data log retrieval responder: packet layout,
  command and reply codes, storage geometry and state encodings.
  Assumes a single 200 MHz clock domain and byte-wide packet streams.
*/
package drlr_pkg;
  // Storage geometry: queues, records per queue, bytes per record string
  localparam int NQ = 4;
  localparam int NR = 4;
  localparam int RB = 80;
  localparam int QW = 2;
  localparam int RW = 2;
  localparam int LW = 7;
  localparam int CW = 3;
  localparam logic [CW-1:0] CNT_FULL = 3'h4;
  localparam logic [LW-1:0] LEN_MAX = 7'h4f;  // Text bytes, NUL not stored
  localparam logic [LW-1:0] LEN_ZERO = 7'h00;
  // Command packet byte positions
  localparam logic [3:0] IX_DST = 4'h0;
  localparam logic [3:0] IX_SRC = 4'h1;
  localparam logic [3:0] IX_CMD = 4'h2;
  localparam logic [3:0] IX_STS = 4'h3;
  localparam logic [3:0] IX_TNL = 4'h4;
  localparam logic [3:0] IX_TNH = 4'h5;
  localparam logic [3:0] IX_FNC = 4'h6;
  localparam logic [3:0] IX_SIZE = 4'h7;
  localparam logic [3:0] IX_FNUM = 4'h8;
  localparam logic [3:0] IX_FTYP = 4'h9;
  localparam logic [3:0] IX_ELEM = 4'ha;
  localparam logic [3:0] IX_SUB = 4'hb;
  localparam logic [3:0] RX_LAST_IX = 4'hb;
  localparam logic [3:0] RX_MAX_IX = 4'hf;
  // Reply header byte positions
  localparam logic [LW-1:0] HX_SRC = 7'h00;
  localparam logic [LW-1:0] HX_DST = 7'h01;
  localparam logic [LW-1:0] HX_CMD = 7'h02;
  localparam logic [LW-1:0] HX_STS = 7'h03;
  localparam logic [LW-1:0] HX_TNL = 7'h04;
  localparam logic [LW-1:0] HX_TNH = 7'h05;
  // Codes
  localparam logic [7:0] CMD_READ = 8'h0f;
  localparam logic [7:0] FNC_READ = 8'ha2;
  localparam logic [7:0] FTYPE_LOG = 8'ha5;
  localparam logic [7:0] CMD_REPLY = 8'h4f;
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_FAIL = 8'hf0;
  localparam logic [7:0] EXT_FAIL = 8'h0e;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] SIZE_MAX = 8'h50;
  localparam logic [7:0] SEP_TAB = 8'h09;
  localparam logic [7:0] SEP_COMMA = 8'h2c;
  localparam logic [7:0] SEP_SPACE = 8'h20;
  localparam logic [1:0] SEL_TAB = 2'h0;
  localparam logic [1:0] SEL_COMMA = 2'h1;
  // Responder states, Gray along receive, check, header, data, ext
  typedef enum logic [2:0] {
    ST_RECV = 3'h0,
    ST_CHECK = 3'h1,
    ST_HDR = 3'h3,
    ST_DATA = 3'h2,
    ST_EXT = 3'h6
  } drlr_state_type;
endpackage

// ### drlr_queue_if.sv
/*
  Bundle between the responder and one log queue state keeper.
  Assumes both ends share clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface drlr_queue_if;
  import drlr_pkg::*;
  logic push;
  logic pop;
  logic clear;
  logic ovf_clr;
  logic [RW-1:0] wr_ptr;
  logic [RW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic full;
  logic overflow;
  modport keeper (input push, pop, clear, ovf_clr,
    output wr_ptr, rd_ptr, count, full, overflow);
  modport user (output push, pop, clear, ovf_clr,
    input wr_ptr, rd_ptr, count, full, overflow);
endinterface
`default_nettype wire

// ### drlr_queue_state.sv
/*
  Per-queue log_queue_state keeper: ring pointers, stored-record count,
  full and sticky overflow flags.
  Assumes push, pop and clear are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module drlr_queue_state
  import drlr_pkg::*;
(
  input wire logic clk,           // System clock
  input wire logic rst_n,         // Synchronous reset, active low
  drlr_queue_if.keeper q          // Queue control and state
);
  logic [RW-1:0] wr_ptr_ff;
  logic [RW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic ovf_ff;
  logic is_full;
  logic do_pop;

  assign is_full = (count_ff == CNT_FULL);
  // A pop on an empty queue removes nothing
  assign do_pop = q.pop && (count_ff != '0);

  // Pointers and count; a push into a full queue drops the oldest
  always_ff @(posedge clk) begin
    if (!rst_n || q.clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (q.push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_pop || (q.push && is_full))
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (q.push && !is_full && !do_pop)
        count_ff <= count_ff + 1'b1;
      else if (do_pop && !q.push)
        count_ff <= count_ff - 1'b1;
    end
  end

  // Overflow is sticky; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n)
      ovf_ff <= 1'b0;
    else if (q.push && is_full && !do_pop)
      ovf_ff <= 1'b1;
    else if (q.ovf_clr)
      ovf_ff <= 1'b0;
  end

  assign q.wr_ptr = wr_ptr_ff;
  assign q.rd_ptr = rd_ptr_ff;
  assign q.count = count_ff;
  assign q.full = is_full;
  assign q.overflow = ovf_ff;
endmodule // drlr_queue_state
`default_nettype wire

// ### drlr_responder.sv
/*
  Data log retrieval responder: stores logged records per queue, answers
  read command packets with the oldest record as a NUL-ended string.
  Assumes byte streams from a link framer on the same clock; the logging
  side presents each field as ASCII decimal or date/time text.
*/
`timescale 1ns/1ps
`default_nettype none
module drlr_responder
  import drlr_pkg::*;
(
  input wire logic clk,                 // System clock, 200 MHz
  input wire logic rst_n,               // Synchronous reset, active low
  input wire logic rx_valid,            // Command byte valid
  input wire logic [7:0] rx_data,       // Command byte
  input wire logic rx_last,             // Last byte of command packet
  output logic rx_ready,                // Responder takes command bytes
  output logic tx_valid,                // Reply byte valid
  output logic [7:0] tx_data,           // Reply byte
  output logic tx_last,                 // Last byte of reply packet
  input wire logic tx_ready,            // Framer takes reply byte
  input wire logic log_valid,           // Logging byte valid
  input wire logic [7:0] log_data,      // Logging byte, ASCII
  input wire logic log_field_end,       // Byte ends a field
  input wire logic log_record_end,      // Byte ends the record
  input wire logic [QW-1:0] log_queue,  // Queue being logged, held
  input wire logic [1:0] field_separator, // 0 tab, 1 comma, else space
  input wire logic program_load,        // Pulse: new program loaded
  input wire logic module_transfer,     // Pulse: memory module transfer
  input wire logic same_program,        // Transfer is autoload of same
  input wire logic [NQ-1:0] ovf_clear,  // Clear overflow flag per queue
  output logic [NQ-1:0] queue_full,     // Queue holds its full count
  output logic [NQ-1:0] queue_overflow, // Record was overwritten
  output logic [NQ*CW-1:0] queue_count  // Stored records per queue
);
  localparam int NS = NQ * NR;

  logic [7:0] mem_ff [NS*RB];
  logic [LW-1:0] len_ff [NS];
  logic [7:0] ck_ff [NS];
  logic [7:0] cmd_ff [RX_LAST_IX+1];
  drlr_state_type state_ff;
  logic [3:0] rx_ix_ff;
  logic rx_bad_ff;
  logic [LW-1:0] ix_ff;
  logic [7:0] xor_ff;
  logic [QW-1:0] rq_ff;
  logic [RW-1:0] rslot_ff;
  logic hit_ff;
  logic fail_ff;
  logic [LW-1:0] wlen_ff;
  logic [7:0] wck_ff;
  logic wsep_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic tx_last_ff;
  logic [RW-1:0] wr_ptr_a [NQ];
  logic [RW-1:0] rd_ptr_a [NQ];
  logic [CW-1:0] count_a [NQ];
  logic [NQ-1:0] pop_v;
  logic [NQ-1:0] push_v;
  logic erase_all;
  logic advance;
  logic cmd_ok;
  logic [7:0] sep;
  logic [$clog2(NS)-1:0] wsel;
  logic [$clog2(NS)-1:0] rsel;
  logic [7:0] rbyte;
  logic [7:0] nxt_byte;
  logic nxt_last;
  logic sep_ins;
  logic room;

  // Erase on program load, or transfer that is not a same-program autoload
  assign erase_all = program_load
    || (module_transfer && !same_program);

  // One state keeper per queue
  for (genvar g = 0; g < NQ; g++) begin : g_q
    drlr_queue_if qi ();
    drlr_queue_state u_qs (.clk(clk), .rst_n(rst_n), .q(qi));
    assign qi.push = push_v[g];
    assign qi.pop = pop_v[g];
    assign qi.clear = erase_all;
    assign qi.ovf_clr = ovf_clear[g];
    assign wr_ptr_a[g] = qi.wr_ptr;
    assign rd_ptr_a[g] = qi.rd_ptr;
    assign count_a[g] = qi.count;
    assign queue_full[g] = qi.full;
    assign queue_overflow[g] = qi.overflow;
    assign queue_count[g*CW +: CW] = qi.count;
    assign push_v[g] = log_valid && log_record_end && (log_queue == g);
    assign pop_v[g] = (state_ff == ST_CHECK) && hit_ff
      && (ix_ff == len_ff[rsel]) && (rq_ff == g);
  end

  // Separator chosen by the user
  always_comb begin
    if (field_separator == SEL_TAB)
      sep = SEP_TAB;
    else if (field_separator == SEL_COMMA)
      sep = SEP_COMMA;
    else
      sep = SEP_SPACE;
  end

  // Writing: a separator goes in before every field but the first
  assign wsel = {log_queue, wr_ptr_a[log_queue]};
  assign sep_ins = wsep_ff;
  assign room = sep_ins ? (wlen_ff < LEN_MAX - 7'h01) : (wlen_ff < LEN_MAX);

  // Text beyond 79 bytes is clipped so the string with NUL fits 80
  always_ff @(posedge clk) begin
    if (log_valid && room) begin
      if (sep_ins) begin
        mem_ff[int'(wsel)*RB + int'(wlen_ff)] <= sep;
        mem_ff[int'(wsel)*RB + int'(wlen_ff) + 1] <= log_data;
      end else begin
        mem_ff[int'(wsel)*RB + int'(wlen_ff)] <= log_data;
      end
    end
  end

  // Record builder: length, checksum, separator pending
  always_ff @(posedge clk) begin
    if (!rst_n || erase_all) begin
      wlen_ff <= LEN_ZERO;
      wck_ff <= BYTE_ZERO;
      wsep_ff <= 1'b0;
    end else if (log_valid) begin
      if (log_record_end) begin
        wlen_ff <= LEN_ZERO;
        wck_ff <= BYTE_ZERO;
        wsep_ff <= 1'b0;
      end else begin
        if (room)
          wlen_ff <= wlen_ff + (sep_ins ? 7'h02 : 7'h01);
        if (room)
          wck_ff <= wck_ff ^ log_data ^ (sep_ins ? sep : BYTE_ZERO);
        wsep_ff <= log_field_end;
      end
    end
  end

  // Length and checksum land with the closing byte
  always_ff @(posedge clk) begin
    if (log_valid && log_record_end) begin
      len_ff[wsel] <= room ? wlen_ff + (sep_ins ? 7'h02 : 7'h01) : wlen_ff;
      ck_ff[wsel] <= room ? (wck_ff ^ log_data ^ (sep_ins ? sep : BYTE_ZERO))
        : wck_ff;
    end
  end

  // Command capture; the packet is checked once complete
  assign rx_ready = (state_ff == ST_RECV) && !tx_valid_ff;
  assign cmd_ok = (cmd_ff[IX_CMD] == CMD_READ)
    && (cmd_ff[IX_FNC] == FNC_READ)
    && (cmd_ff[IX_STS] == BYTE_ZERO)
    && (cmd_ff[IX_FNUM] == BYTE_ZERO)
    && (cmd_ff[IX_FTYP] == FTYPE_LOG)
    && (cmd_ff[IX_SUB] == BYTE_ZERO)
    && (cmd_ff[IX_SIZE] <= SIZE_MAX);

  always_ff @(posedge clk) begin
    if (rx_valid && rx_ready && !rx_bad_ff && rx_ix_ff <= RX_LAST_IX)
      cmd_ff[rx_ix_ff] <= rx_data;
  end

  // Byte counter; short or long packets are dropped without reply
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_ix_ff <= '0;
      rx_bad_ff <= 1'b0;
    end else if (rx_valid && rx_ready) begin
      if (rx_last) begin
        rx_ix_ff <= '0;
        rx_bad_ff <= 1'b0;
      end else begin
        if (rx_ix_ff == RX_MAX_IX)
          rx_bad_ff <= 1'b1;
        else
          rx_ix_ff <= rx_ix_ff + 1'b1;
      end
    end
  end

  assign rsel = {rq_ff, rslot_ff};
  assign rbyte = mem_ff[int'(rsel)*RB + int'(ix_ff)];

  // Main sequence: receive, check, header, string, extended status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_RECV;
      ix_ff <= LEN_ZERO;
      xor_ff <= BYTE_ZERO;
      rq_ff <= '0;
      rslot_ff <= '0;
      hit_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_RECV: begin
          if (rx_valid && rx_ready && rx_last && !rx_bad_ff
            && rx_ix_ff == RX_LAST_IX) begin
            state_ff <= ST_CHECK;
          end
          ix_ff <= LEN_ZERO;
          xor_ff <= BYTE_ZERO;
        end
        ST_CHECK: begin
          // Queue numbers past the built ones read as empty
          if (ix_ff == LEN_ZERO && xor_ff == BYTE_ZERO && !hit_ff) begin
            if (!cmd_ok) begin
              state_ff <= ST_RECV;
            end else begin
              rq_ff <= cmd_ff[IX_ELEM][QW-1:0];
              rslot_ff <= rd_ptr_a[cmd_ff[IX_ELEM][QW-1:0]];
              hit_ff <= (cmd_ff[IX_ELEM] < 8'(NQ))
                && (count_a[cmd_ff[IX_ELEM][QW-1:0]] != '0);
              xor_ff <= 8'h01;
              if (!((cmd_ff[IX_ELEM] < 8'(NQ))
                && (count_a[cmd_ff[IX_ELEM][QW-1:0]] != '0))) begin
                fail_ff <= 1'b0;
                state_ff <= ST_HDR;
              end
            end
          end else if (ix_ff == len_ff[rsel]) begin
            fail_ff <= ((xor_ff ^ 8'h01) != ck_ff[rsel]);
            ix_ff <= LEN_ZERO;
            state_ff <= ST_HDR;
          end else begin
            xor_ff <= xor_ff ^ rbyte;
            ix_ff <= ix_ff + 1'b1;
          end
        end
        ST_HDR: begin
          if (advance) begin
            if (ix_ff == HX_TNH) begin
              ix_ff <= LEN_ZERO;
              state_ff <= fail_ff ? ST_EXT : ST_DATA;
            end else begin
              ix_ff <= ix_ff + 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (advance) begin
            if (!hit_ff || ix_ff == len_ff[rsel]) begin
              hit_ff <= 1'b0;
              state_ff <= ST_RECV;
            end else begin
              ix_ff <= ix_ff + 1'b1;
            end
          end
        end
        ST_EXT: begin
          if (advance) begin
            hit_ff <= 1'b0;
            state_ff <= ST_RECV;
          end
        end
        default: state_ff <= ST_RECV;
      endcase
    end
  end

  // Next reply byte for the header, string and extended status
  always_comb begin
    nxt_byte = BYTE_ZERO;
    nxt_last = 1'b0;
    if (state_ff == ST_HDR) begin
      if (ix_ff == HX_SRC)
        nxt_byte = cmd_ff[IX_DST];
      else if (ix_ff == HX_DST)
        nxt_byte = cmd_ff[IX_SRC];
      else if (ix_ff == HX_CMD)
        nxt_byte = CMD_REPLY;
      else if (ix_ff == HX_STS)
        nxt_byte = fail_ff ? STS_FAIL : STS_OK;
      else if (ix_ff == HX_TNL)
        nxt_byte = cmd_ff[IX_TNL];
      else
        nxt_byte = cmd_ff[IX_TNH];
    end else if (state_ff == ST_DATA) begin
      // An empty queue sends only the terminator
      nxt_last = !hit_ff || (ix_ff == len_ff[rsel]);
      nxt_byte = nxt_last ? BYTE_ZERO : rbyte;
    end else if (state_ff == ST_EXT) begin
      nxt_byte = EXT_FAIL;
      nxt_last = 1'b1;
    end
  end

  // Output register stage; the generator stalls while it is held
  assign advance = ((state_ff == ST_HDR) || (state_ff == ST_DATA)
    || (state_ff == ST_EXT)) && (!tx_valid_ff || tx_ready);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= BYTE_ZERO;
      tx_last_ff <= 1'b0;
    end else if (advance) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= nxt_byte;
      tx_last_ff <= nxt_last;
    end else if (tx_ready) begin
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign tx_last = tx_last_ff;
endmodule // drlr_responder
`default_nettype wire

// ### drlr_responder_properties.sv
/*
  Checker for the retrieval responder: reply framing, hold, erase, counts.
  Assumes it is bound to the responder and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module drlr_responder_checker
  import drlr_pkg::*;
(
  input wire logic clk,                   // Clock
  input wire logic rst_n,                 // Reset, active low
  input wire logic rx_valid,              // Command valid
  input wire logic [7:0] rx_data,         // Command byte
  input wire logic rx_last,               // Command last
  input wire logic rx_ready,              // Command ready
  input wire logic tx_valid,              // Reply valid
  input wire logic [7:0] tx_data,         // Reply byte
  input wire logic tx_last,               // Reply last
  input wire logic tx_ready,              // Reply ready
  input wire logic log_valid,             // Log valid
  input wire logic [7:0] log_data,        // Log byte
  input wire logic log_field_end,         // Field end
  input wire logic log_record_end,        // Record end
  input wire logic [QW-1:0] log_queue,    // Log queue
  input wire logic [1:0] field_separator, // Separator
  input wire logic program_load,          // Program load
  input wire logic module_transfer,       // Module transfer
  input wire logic same_program,          // Same program
  input wire logic [NQ-1:0] ovf_clear,    // Overflow clear
  input wire logic [NQ-1:0] queue_full,   // Full flags
  input wire logic [NQ-1:0] queue_overflow, // Overflow flags
  input wire logic [NQ*CW-1:0] queue_count  // Counts
);
  logic [LW-1:0] idx_ff;
  logic [7:0] sts_ff;
  logic [NQ-1:0] exp_full;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Byte position inside the reply, back to zero after the last byte
  always_ff @(posedge clk) begin
    if (!rst_n) idx_ff <= LEN_ZERO;
    else if (tx_valid && tx_ready) idx_ff <= tx_last ? LEN_ZERO : idx_ff + 1'b1;
  end
  // Status byte of the reply, so the closing byte can be judged
  always_ff @(posedge clk) begin
    if (!rst_n) sts_ff <= STS_OK;
    else if (tx_valid && tx_ready && idx_ff == HX_STS) sts_ff <= tx_data;
  end
  // Full is a pure function of the stored count
  always_comb begin
    for (int g = 0; g < NQ; g++) begin
      exp_full[g] = (queue_count[g*CW +: CW] == CNT_FULL);
    end
  end
  reply_code_a: assert property (
    tx_valid && idx_ff == HX_CMD |-> tx_data == CMD_REPLY)
    else $error("reply command byte wrong");
  end_byte_a: assert property (
    tx_valid && tx_last |->
    tx_data == ((sts_ff == STS_FAIL) ? EXT_FAIL : BYTE_ZERO))
    else $error("closing reply byte wrong");
  reply_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte dropped before taken");
  busy_refuse_a: assert property (
    tx_valid |-> !rx_ready)
    else $error("command taken during reply");
  load_erase_a: assert property (
    program_load && !log_valid |=> queue_count == '0)
    else $error("program load kept records");
  transfer_erase_a: assert property (
    module_transfer && !same_program && !log_valid |=> queue_count == '0)
    else $error("module transfer kept records");
  transfer_keep_a: assert property (
    module_transfer && same_program && rx_ready && !log_valid && !program_load
    |=> $stable(queue_count))
    else $error("autoload of same program lost records");
  idle_count_a: assert property (
    rx_ready && !log_valid && !program_load && !module_transfer
    |=> $stable(queue_count))
    else $error("count changed with no read or log");
  full_flag_a: assert property (
    queue_full == exp_full)
    else $error("full flag disagrees with count");
  ovf_sticky_a: assert property (
    1'b1 |=> (queue_overflow | ~$past(queue_overflow) | $past(ovf_clear)) == '1)
    else $error("overflow flag dropped on its own");
  cover property (tx_valid && tx_ready && tx_last && idx_ff > HX_TNH);
  cover property (program_load);
  cover property ($rose(queue_overflow[2]));
endmodule // drlr_responder_checker
bind drlr_responder drlr_responder_checker u_chk (
  .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
  .log_valid(log_valid), .log_data(log_data), .log_field_end(log_field_end),
  .log_record_end(log_record_end), .log_queue(log_queue),
  .field_separator(field_separator), .program_load(program_load),
  .module_transfer(module_transfer), .same_program(same_program),
  .ovf_clear(ovf_clear), .queue_full(queue_full),
  .queue_overflow(queue_overflow), .queue_count(queue_count));
`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for the retrieval responder.
  Assumes the host model drives the command side and collects replies.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drlr_pkg::*;
  typedef struct {logic [1:0] q; logic [1:0] sel; logic [15:0] transaction_number;
    string txt;} drlr_row_type;
  logic clk, rst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data, log_data;
  logic log_valid, log_field_end, log_record_end, program_load, slow;
  logic module_transfer, same_program;
  logic [QW-1:0] log_queue;
  logic [1:0] field_separator;
  logic [NQ-1:0] ovf_clear, queue_full, queue_overflow;
  logic [NQ*CW-1:0] queue_count;
  drlr_row_type rows[4];
  logic [3:0] ixs[7];
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  drlr_responder u_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .log_valid(log_valid), .log_data(log_data),
    .log_field_end(log_field_end), .log_record_end(log_record_end),
    .log_queue(log_queue), .field_separator(field_separator),
    .program_load(program_load), .module_transfer(module_transfer),
    .same_program(same_program), .ovf_clear(ovf_clear),
    .queue_full(queue_full), .queue_overflow(queue_overflow),
    .queue_count(queue_count));
  drlr_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard: the run needs under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [CW-1:0] cnt(input int q);
    return queue_count[q*CW +: CW];
  endfunction
  function automatic logic [7:0] sep_of(input logic [1:0] sel);
    return sel == SEL_TAB ? SEP_TAB : sel == SEL_COMMA ? SEP_COMMA : SEP_SPACE;
  endfunction
  // A bar in the text ends the field whose byte stands before it
  task automatic log_str(input logic [1:0] q, input logic [1:0] sel,
      input string s);
    for (int i = 0; i < s.len(); i++) begin
      if (s[i] == "|") continue;
      log_valid = 1'b1;
      log_queue = q;
      field_separator = sel;
      log_data = s[i];
      log_field_end = (i + 1 < s.len()) && (s[i+1] == "|");
      log_record_end = (i == s.len() - 1);
      step(1);
    end
    log_valid = 1'b0;
    log_field_end = 1'b0;
    log_record_end = 1'b0;
  endtask
  // Read one record and compare the whole reply byte by byte
  task automatic read_chk(input logic [7:0] elem, input logic [15:0] transaction_number,
      input string s, input logic [7:0] sep);
    logic [7:0] e[$];
    int n0;
    int w;
    e = '{8'h01, 8'h02, CMD_REPLY, STS_OK, transaction_number[7:0], transaction_number[15:8]};
    for (int i = 0; i < s.len(); i++) e.push_back(s[i] == "|" ? sep : s[i]);
    e.push_back(BYTE_ZERO);
    u_host.rep.delete();
    n0 = u_host.n_last;
    u_host.send_read(transaction_number, elem, RX_MAX_IX);
    w = 0;
    while (u_host.n_last == n0 && w < 400) begin
      step(1);
      w++;
    end
    check(u_host.rep.size(), e.size());
    foreach (e[i]) check(u_host.rep[i], e[i]);
  endtask
  initial begin
    rst_n = 1'b0;
    log_valid = 1'b0;
    log_data = 8'h00;
    log_field_end = 1'b0;
    log_record_end = 1'b0;
    log_queue = 2'h0;
    field_separator = 2'h0;
    program_load = 1'b0;
    module_transfer = 1'b0;
    same_program = 1'b0;
    ovf_clear = 4'h0;
    slow = 1'b0;
    rows = '{'{2'h0, 2'h0, 16'h1234, "12|3"},
      '{2'h1, 2'h1, 16'h00ff, "07/04/2024|10:20:30|-5"},
      '{2'h2, 2'h2, 16'hab01, "7"}, '{2'h3, 2'h3, 16'h8000, "1|2|3"}};
    ixs = '{IX_CMD, IX_STS, IX_FNC, IX_SIZE, IX_FNUM, IX_FTYP, IX_SUB};
    step(16);
    rst_n = 1'b1;
    step(1);
    // Idle state after reset
    check(tx_valid, 1'b0);
    check(rx_ready, 1'b1);
    check(queue_count, 12'h000);
    check(queue_overflow, 4'h0);
    // Plain records, every separator code, stalls on odd rows
    foreach (rows[k]) begin
      slow = k[0];
      log_str(rows[k].q, rows[k].sel, rows[k].txt);
      check(cnt(rows[k].q), 3'h1);
      read_chk(8'(rows[k].q), rows[k].transaction_number, rows[k].txt,
        sep_of(rows[k].sel));
      check(cnt(rows[k].q), 3'h0);
    end
    // Empty queue and a queue number beyond the built ones
    read_chk(8'h00, 16'h5a5a, "", 8'h00);
    read_chk(8'hff, 16'h0102, "", 8'h00);
    check(queue_count, 12'h000);
    // Back-to-back records come out oldest first, once each
    log_str(2'h1, 2'h0, "5");
    log_str(2'h1, 2'h0, "6");
    read_chk(8'h01, 16'h1111, "5", 8'h00);
    read_chk(8'h01, 16'h2222, "6", 8'h00);
    read_chk(8'h01, 16'h3333, "", 8'h00);
    // Fifth record into a four-slot queue overwrites the oldest
    for (int i = 1; i <= 5; i++) begin
      log_str(2'h2, 2'h0, $sformatf("%0d", i));
      if (i == 4) check(queue_full[2], 1'b1);
    end
    check(queue_overflow[2], 1'b1);
    check(cnt(2), 3'h4);
    read_chk(8'h02, 16'h4444, "2", 8'h00);
    check(queue_full[2], 1'b0);
    ovf_clear = 4'h4;
    step(1);
    ovf_clear = 4'h0;
    step(1);
    check(queue_overflow[2], 1'b0);
    // Malformed commands get no reply and remove nothing
    foreach (ixs[k]) begin
      u_host.rep.delete();
      u_host.send_read(16'h0007, 8'h02, ixs[k]);
      step(40);
      check(u_host.rep.size(), 0);
      check(cnt(2), 3'h3);
    end
    log_str(2'h2, 2'h0, "6");
    log_valid = 1'b1; // Clobbers oldest slot
    step(1);
    log_valid = 1'b0;
    u_host.send_read(16'h0e0e, 8'h02, RX_MAX_IX);
    step(60);
    check(u_host.rep.size(), 7);
    check({u_host.rep[3], u_host.rep[6]}, {STS_FAIL, EXT_FAIL});
    // Erase conditions
    {module_transfer, same_program} = 2'b11;
    step(1);
    {module_transfer, same_program} = 2'b00;
    step(1);
    check(cnt(2), 3'h3);
    module_transfer = 1'b1;
    step(1);
    module_transfer = 1'b0;
    step(1);
    check(queue_count, 12'h000);
    log_str(2'h0, 2'h0, "9");
    log_str(2'h3, 2'h1, "8");
    program_load = 1'b1;
    step(1);
    program_load = 1'b0;
    step(1);
    check(queue_count, 12'h000);
    read_chk(8'h00, 16'h4321, "", 8'h00);
    summarize();
  end
endmodule // tb
`default_nettype wire
